//--- inc/tbi_defs.vh
// Constants for the transmit telecom bus indicator block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef TBI_DEFS_VH
`define TBI_DEFS_VH

// Register port
`define TBI_ADDR_W          16
`define TBI_CTRL_ADDR       16'h0137
`define TBI_CTRL_RESET      8'h00

// Control register field positions
`define TBI_BIT_ENABLE      0
`define TBI_BIT_REPHASE_OFF 1
`define TBI_BIT_PAR_ODD     2
`define TBI_BIT_PAR_WIDE    3
`define TBI_BIT_PROTECT     4
`define TBI_BIT_PCLK_OUT    5

// Bus clock synthesis: 19.44 MHz from 100 MHz by phase accumulation
`define TBI_SYS_KHZ         100000
`define TBI_BUS_KHZ         19440
`define TBI_ACC_W           18
`define TBI_ACC_STEP        18'h04BF0
`define TBI_ACC_MOD         18'h186A0
`define TBI_ACC_HALF        18'h0C350

`endif

//--- design/tbi_clock_synth.v
// Fractional divider making the 19.44 MHz telecom bus clock from clk.
// Assumes a 100 MHz clk; the output has one clk period of edge jitter.
`timescale 1ns/1ps
`include "tbi_defs.vh"

module tbi_clock_synth
(
   // Clock and reset
   input  wire clk,
   input  wire rstn,
   input  wire ce,
   // Generated bus clock
   output reg  busClk,
   output reg  busTick
);

   reg  [`TBI_ACC_W-1:0] acc;        // Phase accumulator
   wire [`TBI_ACC_W:0]   sum;        // Unwrapped next phase
   wire                  wrap;       // Phase crosses a full period
   wire [`TBI_ACC_W-1:0] next_acc;   // Wrapped next phase

   assign sum      = {1'b0, acc} + {1'b0, `TBI_ACC_STEP};
   assign wrap     = (sum >= {1'b0, `TBI_ACC_MOD});
   assign next_acc = wrap ? sum[`TBI_ACC_W-1:0] - `TBI_ACC_MOD : sum[`TBI_ACC_W-1:0];

   // Tick flags a phase wrap; the clock follows the phase one cycle late,
   // so it rises on the edge after the tick, where the bus pins load
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         acc     <= {`TBI_ACC_W{1'b0}};
         busClk  <= 1'b0;
         busTick <= 1'b0;
      end
      else if (ce)
      begin
         acc     <= next_acc;
         busClk  <= (acc < `TBI_ACC_HALF);
         busTick <= wrap;
      end
   end

endmodule // tbi_clock_synth

//--- design/tbi_tx_bus.v
// Transmit side of the STS-3/STM-1 telecom bus output port.
// Assumes the framer supplies each byte with its markers in the cycle
// that byteReq is high, and software owns the control register port.
`timescale 1ns/1ps
`include "tbi_defs.vh"

module tbi_tx_bus
(
   // Clock, reset, enable
   input  wire                   clk,
   input  wire                   rstn,
   input  wire                   ce,
   // Control register port
   input  wire [`TBI_ADDR_W-1:0] regAddr,
   input  wire                   regWrite,
   input  wire                   regRead,
   input  wire [7:0]             regWdata,
   output reg  [7:0]             regRdata,
   output reg                    regAck,
   // Byte stream from the framer
   output wire                   byteReq,
   input  wire [7:0]             inData,
   input  wire                   inIsOverhead,
   input  wire                   inIsC1,
   input  wire                   inIsJ1,
   input  wire                   inPathAis,
   // Protect bus signals in ATM/PPP modes
   input  wire                   protectClkIn,
   input  wire                   protectParity,
   // Telecom bus pins
   output wire                   txBusClockOut,
   output wire                   txBusClockOe,
   output reg  [7:0]             txBusData,
   output reg                    txBytePhaseIndicator,
   output reg                    txAlarmIndicator,
   output wire                   txAlarmOe,
   output reg                    txBusParity,
   output reg                    txPayloadIndicator
);

   // Control register layout, one byte at the register address:
   //   bit 0    bus enable, byte stream and parity run
   //   bit 1    rephase off, phase and alarm indicators qualify
   //   bit 2    parity sense, set for odd
   //   bit 3    parity scope, set to add payload and phase markers
   //   bit 4    protect mode, pins take their ATM/PPP roles
   //   bit 5    protect clock and alarm pins driven, else inputs in protect mode
   //   bits 7:6 stored and read back, no effect
   // Reset value clears every field: bus off, not in protect mode.
   // Fields act at once; a parity or rephase change lands on the next bus byte.

   // Register and generated clock
   reg  [7:0] telecomBusControl;     // Control register
   wire       busClk;                // Synthesised bus clock
   wire       busTick;               // Bus clock rising edge

   // Decoded control fields
   wire       busEnable;             // Bus carries the STS-3 stream
   wire       rephaseOffMode;        // Rephase off selected
   wire       parOdd;                // Odd parity sense
   wire       parWide;               // Parity over data plus markers
   wire       protectMode;           // ATM or PPP over STS-3c
   wire       protectClkDrive;       // Protect clock driven by us
   wire       indicatorsOn;          // Phase and alarm qualify
   wire       ctrlHit;               // Address matches control reg

   // Markers computed for the byte being taken
   reg        next_phase;            // Phase indicator for next byte
   reg        next_payload;          // Payload indicator for next byte
   reg        next_alarm;            // Alarm for next byte

   assign busEnable       = telecomBusControl[`TBI_BIT_ENABLE];
   assign rephaseOffMode  = telecomBusControl[`TBI_BIT_REPHASE_OFF];
   assign parOdd          = telecomBusControl[`TBI_BIT_PAR_ODD];
   assign parWide         = telecomBusControl[`TBI_BIT_PAR_WIDE];
   assign protectMode     = telecomBusControl[`TBI_BIT_PROTECT];
   assign protectClkDrive = telecomBusControl[`TBI_BIT_PCLK_OUT];
   assign indicatorsOn    = busEnable & rephaseOffMode & ~protectMode;
   assign ctrlHit         = (regAddr == `TBI_CTRL_ADDR);

   // Parity of a byte plus two marker bits, sense selectable.
   // Even sense makes the XOR of all covered bits and the parity
   // bit zero; odd sense inverts that. Narrow scope ignores the
   // markers, so they may carry any value then.
   function parity10;
      input [7:0] data;
      input       pl;
      input       phase;
      input       wide;
      input       odd;
      begin
         parity10 = (^data) ^ (wide & (pl ^ phase)) ^ odd;
      end
   endfunction

   // Bus clock generator
   // Runs free while the bus is disabled, so the sink keeps a clock
   tbi_clock_synth uSynth
   (
      .clk     (clk),
      .rstn    (rstn),
      .ce      (ce),
      .busClk  (busClk),
      .busTick (busTick)
   );

   // Clock pin: bus clock normally, protect clock only in protect mode
   // In protect mode the pin follows the protect clock only when driven
   assign txBusClockOut = protectMode ? protectClkIn & protectClkDrive : busClk;
   assign txBusClockOe  = ~protectMode | protectClkDrive;
   // Alarm pin turns round only in protect mode
   assign txAlarmOe     = ~protectMode | protectClkDrive;

   // Byte timing, in clk cycles of one bus period:
   //   c0   busTick high, byteReq asks the framer, inputs sampled
   //   c1   bus clock rises and every bus pin loads on that edge
   //   c2+  pins hold until the next byteReq, 5 or 6 cycles on
   // Asking one cycle ahead of the rise keeps every pin launched by
   // the same edge as the clock pin, so the sink sees no skew.
   // byteReq stays low while disabled or in protect mode.
   // Framer is asked for a byte once per bus clock period
   assign byteReq = ce & busTick & busEnable & ~protectMode;

   // Indicator values for the byte being taken
   always @*
   begin
      // C1 counts as overhead even when not flagged
      next_payload = ~inIsOverhead & ~inIsC1;
      // J1 marks phase only inside payload
      next_phase   = indicatorsOn & (inIsC1 | (inIsJ1 & next_payload));
      // Alarm follows the path's AIS state byte by byte
      next_alarm   = indicatorsOn & inPathAis;
   end

   // Control register: write and registered read back
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         telecomBusControl <= `TBI_CTRL_RESET;
         regRdata          <= 8'h00;
         regAck            <= 1'b0;
      end
      else if (ce)
      begin
         // Every strobe is acknowledged, mapped or not, so software never stalls
         regAck <= regWrite | regRead;
         // Software picks parity sense and scope here
         if (regWrite && ctrlHit)
         begin
            telecomBusControl <= regWdata;
         end
         // Unmapped reads return zero
         // Read data is registered and stays until the next read
         if (regRead)
         begin
            regRdata <= ctrlHit ? telecomBusControl : 8'h00;
         end
      end
   end

   // Output stage: every pin of a byte loads on the same bus clock rise
   // A low ce freezes every pin except the protect-mode clock pin, with the rest of the state
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         txBusData            <= 8'h00;
         txBytePhaseIndicator <= 1'b0;
         txAlarmIndicator     <= 1'b0;
         txBusParity          <= 1'b0;
         txPayloadIndicator   <= 1'b0;
      end
      else if (ce)
      begin
         if (protectMode)
         begin
            // Alarm pin carries protect parity; bus markers idle
            // Payload marker holds; the pin is not a bus output here
            txAlarmIndicator     <= protectParity;
            txBytePhaseIndicator <= 1'b0;
            txBusParity          <= 1'b0;
         end
         else if (!busEnable)
         begin
            // Disabled bus: indicators and parity held low
            // Data byte keeps its last value while no byte is taken
            txBytePhaseIndicator <= 1'b0;
            txAlarmIndicator     <= 1'b0;
            txBusParity          <= 1'b0;
            txPayloadIndicator   <= 1'b0;
         end
         else if (busTick)
         begin
            // One byte per bus period, phase pulse lasts that period
            // Markers and parity come from the same inputs as the data
            txBusData            <= inData;
            txPayloadIndicator   <= next_payload;
            txBytePhaseIndicator <= next_phase;
            txAlarmIndicator     <= next_alarm;
            txBusParity          <= parity10(inData, next_payload, next_phase,
                                             parWide, parOdd);
         end
      end
   end

endmodule // tbi_tx_bus

//--- sim/tbi_checker.sv
// Checker for the transmit telecom bus outputs.
// Sees only the top ports; bound from the testbench.
`timescale 1ns/1ps
module tbi_checker
(
   // Clock and reset
   input wire       clk,
   input wire       rstn,
   // Requests
   input wire       regWrite,
   input wire       regRead,
   input wire       regAck,
   input wire       byteReq,
   input wire [7:0] inData,
   input wire       inIsOverhead,
   input wire       inIsC1,
   input wire       inIsJ1,
   input wire       inPathAis,
   // Bus pins
   input wire       txBusClockOut,
   input wire [7:0] txBusData,
   input wire       txBytePhaseIndicator,
   input wire       txAlarmIndicator,
   input wire       txPayloadIndicator
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Bytes at most once per bus period
   sequence quietGap; !byteReq[*4]; endsequence
   byte_gap_a: assert property (byteReq |=> quietGap) else $error("gap");
   clock_rise_a: assert property (byteReq |=> $rose(txBusClockOut)) else $error("clk");
   data_hold_a: assert property (!byteReq |=> $stable(txBusData)) else $error("hold");
   data_align_a: assert property (byteReq |=> txBusData == $past(inData)) else $error("d");
   c1_payload_a: assert property (byteReq && inIsC1 |=> !txPayloadIndicator) else $error("c1");
   payload_mark_a: assert property (byteReq && !inIsC1 |=>
      txPayloadIndicator == !$past(inIsOverhead)) else $error("pl");
   phase_quiet_a: assert property (byteReq && !inIsC1 && !inIsJ1 |=>
      !txBytePhaseIndicator) else $error("phase");
   alarm_quiet_a: assert property (byteReq && !inPathAis |=> !txAlarmIndicator) else $error("al");
   reg_ack_a: assert property (regWrite || regRead |=> regAck) else $error("ack");
endmodule // tbi_checker

//--- sim/tbi_bus_sink.sv
// Downstream model latching the bus mid-period.
// Expects the transmit bus clock and data pins.
`timescale 1ns/1ps
module tbi_bus_sink
(
   // Bus pins
   input wire       busClk,
   input wire [7:0] busData,
   // Captured byte
   output reg [7:0] seenData
);
   // Sample away from the launching edge
   always @(negedge busClk)
   begin
      seenData <= busData;
   end
endmodule // tbi_bus_sink

//--- sim/testbench.sv
// Bench for the transmit telecom bus block.
// Drives framer side and control port; a sink watches the bus.
`timescale 1ns/1ps
`include "tbi_defs.vh"
module testbench;
   reg        clk, rstn, regWrite, regRead, inIsOverhead, inIsC1, inIsJ1, inPathAis;
   reg        protectClkIn, protectParity;
   reg [15:0] regAddr;
   reg [7:0]  regWdata, inData, ctrl;
   wire [7:0] regRdata, txBusData, seenData;
   wire       regAck, byteReq, txBusClockOut, txBusClockOe, txBytePhaseIndicator;
   wire       txAlarmIndicator, txAlarmOe, txBusParity, txPayloadIndicator;
   integer    fail_count, checks, cyc, m;
   tbi_tx_bus i_tbi_tx_bus (.clk(clk), .rstn(rstn), .ce(1'b1), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
      .regAck(regAck), .byteReq(byteReq), .inData(inData), .inIsOverhead(inIsOverhead),
      .inIsC1(inIsC1), .inIsJ1(inIsJ1), .inPathAis(inPathAis), .protectClkIn(protectClkIn),
      .protectParity(protectParity), .txBusClockOut(txBusClockOut),
      .txBusClockOe(txBusClockOe), .txBusData(txBusData),
      .txBytePhaseIndicator(txBytePhaseIndicator), .txAlarmIndicator(txAlarmIndicator),
      .txAlarmOe(txAlarmOe), .txBusParity(txBusParity),
      .txPayloadIndicator(txPayloadIndicator));
   tbi_bus_sink i_tbi_bus_sink (.busClk(txBusClockOut), .busData(txBusData),
      .seenData(seenData));
   // Compare and count
   task chk(input [79:0] name, input [7:0] exp, input [7:0] got);
   begin
      checks = checks + 1;
      if (got !== exp)
      begin
         fail_count = fail_count + 1;
         $display("wrong value %0s expected %h seen %h", name, exp, got);
      end
   end
   endtask
   // One register access, write when w
   task acc(input w, input [15:0] a, input [7:0] d);
   begin
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= w;
      regRead <= !w;
      @(posedge clk);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      #1 chk("ack", 8'h01, regAck);
   end
   endtask
   // Offer one byte and check the bus after it is taken
   task sendByte(input [7:0] d, input oh, input c1, input j1, input ais);
      reg en, pl, ph;
   begin
      en = ctrl[0] & ctrl[1];
      pl = !(oh | c1);
      ph = en & (c1 | j1 & pl);
      @(posedge clk);
      inData <= d;
      inIsOverhead <= oh;
      inIsC1 <= c1;
      inIsJ1 <= j1;
      inPathAis <= ais;
      @(negedge clk);
      while (byteReq !== 1'b1) @(negedge clk);
      @(posedge clk);
      #1 chk("data", d, txBusData);
      chk("payload", pl, txPayloadIndicator);
      chk("phase", ph, txBytePhaseIndicator);
      chk("alarm", en & ais, txAlarmIndicator);
      chk("parity", ^d ^ ctrl[2] ^ (ctrl[3] & (pl ^ ph)), txBusParity);
      @(negedge txBusClockOut) #1 chk("sink", d, seenData);
   end
   endtask
   // Verdict and end of run
   task results;
   begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 3000)
      begin
         fail_count = fail_count + 1;
         results;
      end
   end
   initial
   begin
      {rstn, regWrite, regRead, inIsOverhead, inIsC1, inIsJ1, inPathAis, protectClkIn} = 8'h00;
      {regAddr, regWdata, inData, ctrl} = 40'h0;
      protectParity = 1'b1;
      fail_count = 0;
      checks = 0;
      cyc = 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      acc(0, `TBI_CTRL_ADDR, 8'h00);
      chk("reset", `TBI_CTRL_RESET, regRdata);
      acc(1, 16'h0138, 8'hFF);
      acc(0, 16'h0138, 8'h00);
      chk("unmapped", 8'h00, regRdata);
      for (m = 0; m < 5; m = m + 1)
      begin
         ctrl = (m == 4) ? 8'h05 : {4'h0, m[1:0], 2'h3};
         acc(1, `TBI_CTRL_ADDR, ctrl);
         acc(0, `TBI_CTRL_ADDR, 8'h00);
         chk("ctrl", ctrl, regRdata);
         sendByte(8'h11 + m[7:0], 1'b1, 1'b1, 1'b0, 1'b0);
         sendByte(8'h6C ^ m[7:0], 1'b0, 1'b0, 1'b1, 1'b1);
         sendByte(8'hF0 | m[7:0], 1'b1, 1'b0, 1'b0, 1'b1);
         sendByte(8'h80 + m[7:0], 1'b0, 1'b0, 1'b0, 1'b0);
      end
      acc(1, `TBI_CTRL_ADDR, 8'h00);
      repeat (8) @(posedge clk);
      #1 chk("off par", 8'h00, txBusParity);
      ctrl = 8'h30;
      acc(1, `TBI_CTRL_ADDR, ctrl);
      @(posedge clk);
      protectClkIn <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("prot par", 8'h01, txAlarmIndicator);
      chk("clk oe", 8'h01, txBusClockOe);
      chk("clk pin", 8'h01, txBusClockOut);
      chk("alarm oe", 8'h01, txAlarmOe);
      chk("no byte", 8'h00, byteReq);
      acc(1, `TBI_CTRL_ADDR, 8'h10);
      repeat (3) @(posedge clk);
      #1 chk("clk in", 8'h00, txBusClockOe);
      chk("alarm in", 8'h00, txAlarmOe);
      results;
   end
endmodule // testbench
bind tbi_tx_bus tbi_checker i_tbi_checker (.*);
